// *** dsi_pkg.sv ***
// Package with register map, field layout, reset values and timing counts of the SPI port
package dsi_pkg;

   // ****************************************************************
   // Register map (byte addresses, one 32-bit word each)
   // ****************************************************************
   localparam logic [7:0] DSI_ADDR_CTRL  = 8'h00;
   localparam logic [7:0] DSI_ADDR_DATA  = 8'h04;
   localparam logic [7:0] DSI_ADDR_CFG   = 8'h08;
   localparam logic [7:0] DSI_ADDR_STAT  = 8'h0C;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int DSI_BIT_CKS  = 7;
   localparam int DSI_BIT_M1   = 6;
   localparam int DSI_BIT_M0   = 5;
   localparam int DSI_BIT_BUS_ENABLE_BIT = 4;
   localparam int DSI_BIT_MLS  = 3;
   localparam int DSI_BIT_SELECT_ENABLE = 2;
   localparam int DSI_BIT_WRITE_COLLISION_FLAG = 1;
   localparam int DSI_BIT_TRF  = 0;
   localparam logic [7:0] DSI_CTRL_RESET = 8'h60;

   // Configuration register fields (polarity, collision enable)
   localparam int DSI_BIT_CPOL    = 0;
   localparam int DSI_BIT_WRITE_COLLISION_FLAG_EN = 1;
   localparam logic [1:0] DSI_CFG_RESET = 2'h2;

   // ****************************************************************
   // Mode encodings and baud half-period counts (system clocks)
   // ****************************************************************
   typedef enum logic [1:0] {
      DSI_MODE_FAST  = 2'b00,
      DSI_MODE_MID   = 2'b01,
      DSI_MODE_SLOW  = 2'b10,
      DSI_MODE_SLAVE = 2'b11
   } dsi_mode_e;

   // Fast half period must outlast the input synchroniser delay, or the master samples a stale bit
   localparam logic [7:0] DSI_HALF_FAST = 8'h06;
   localparam logic [7:0] DSI_HALF_MID  = 8'h08;
   localparam logic [7:0] DSI_HALF_SLOW = 8'h20;
   localparam int         DSI_CKS_SHIFT = 2;
   localparam logic [3:0] DSI_WORD_BITS = 4'h8;
   localparam logic [4:0] DSI_HALF_STEPS = 5'h10;

   // Synchroniser lane order
   localparam int DSI_LANE_SDI  = 0;
   localparam int DSI_LANE_CS   = 1;
   localparam int DSI_LANE_SCLK = 2;

endpackage

// *** dsi_link_if.sv ***
// Interface carrying raw and synchronised pin levels between port core and synchroniser
`timescale 1ns/1ps
interface dsi_link_if #(
   parameter int LANES = 3
);
   logic [LANES-1:0] raw;
   logic [LANES-1:0] clean;

   modport sync (input raw, output clean);
   modport core (output raw, input clean);
endinterface

// *** dsi_sync.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module dsi_sync
   import dsi_pkg::*;
#(
   parameter int LANES = 3
) (
   input  wire logic clk,
   input  wire logic rst,
   dsi_link_if.sync  link
);

   logic [LANES-1:0] stage1;
   logic [LANES-1:0] stage2;
   logic [LANES-1:0] stage3;

   // Shift chain; stage1 feeds stage2 only
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= link.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Accept a new level only when the late stages agree, filtering runt glitches
   always_ff @(posedge clk) begin
      if (rst) begin
         link.clean <= '0;
      end else begin
         for (int i = 0; i < LANES; i++) begin
            if (stage2[i] == stage3[i]) begin
               link.clean[i] <= stage3[i];
            end
         end
      end
   end

endmodule

// *** dsi_baud.sv ***
// Baud divider giving a one-cycle enable pulse every half period
`timescale 1ns/1ps
module dsi_baud
   import dsi_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [7:0] half,
   output logic            tick
);

   logic [7:0] count;

   // Up counter restarted while idle so the first half period is full length
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         count <= 8'h00;
         tick  <= 1'b0;
      end else if (count >= half - 8'h01) begin
         count <= 8'h00;
         tick  <= 1'b1;
      end else begin
         count <= count + 8'h01;
         tick  <= 1'b0;
      end
   end

endmodule

// *** dsi_spi_port.sv ***
// SPI serial port core with APB register access, master clock generation and slave shifting
//
// Behaviour
// - Four lines: data in, out, clock, select
// - Select line active only when select enabled
// - Control register resets with mode bits set
// - Data register has no reset value
// - Data writes load shifter; reads return latch
// - Master data write starts the transfer
// - Done flag set after all bits shift
// - Slave shifts on each received clock
// - Enabled idle: output line high; a selected slave shows its first bit
// - Master idles clock at polarity; slave floats
// - Bus disabled: all four lines float
// - Master alone generates the serial clock
// - Mode 00/01/10 select master baud rates
// - Clock source bit picks master clock base
// - Bit order selects MSB or LSB first
// - Only master starts; full-duplex data
// - Write during transfer sets collision, dropped
// - Done flag low while master shifts
// - Done flag raises request; runs in power-down
`timescale 1ns/1ps
module dsi_spi_port
   import dsi_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_in_line,
   output logic             serial_out_line,
   output logic             serial_out_oe,
   input  wire logic        serial_clock_in,
   output logic             serial_clock_out,
   output logic             serial_clock_oe,
   input  wire logic        slave_select_in,
   output logic             slave_select_out,
   output logic             slave_select_oe,
   output logic             serial_irq
);

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   logic       clock_source_select;
   dsi_mode_e  mode;
   logic       bus_enable_bit;
   logic       bit_order_select;
   logic       select_enable_bit;
   logic       write_collision_flag;
   logic       transfer_done_flag;
   logic       cpol;
   logic       write_collision_flag_en;
   logic [7:0] serial_port_data;
   logic [7:0] shift_buffer;
   logic       sampled_bit;
   logic [4:0] half_step;
   logic [3:0] slave_bits;
   logic       master_busy;
   logic       sclk_prev;

   logic       is_master;
   logic       busy;
   logic       acc;
   logic       wr_en;
   logic       map_hit;
   logic       data_wr;
   logic       collide;
   logic       tick;
   logic [7:0] next_half;
   logic       slave_sel;
   logic       sclk_s;
   logic       lead_edge;
   logic       in_bit;
   logic       shift_now;
   logic       sample_now;
   logic       word_done;
   logic       out_bit;

   // ****************************************************************
   // Pin synchroniser and baud divider
   // ****************************************************************
   dsi_link_if #(.LANES(3)) link ();

   // Raw lanes in one assignment, clock lane on top; the core only looks at the clean copies
   assign link.raw = {serial_clock_in, slave_select_in, serial_in_line};

   dsi_sync #(.LANES(3)) u_sync (
      .clk  (clk),
      .rst  (rst),
      .link (link.sync)
   );

   // Half period from mode, stretched when the slow source is chosen
   always_comb begin
      case (mode)
         DSI_MODE_FAST: next_half = DSI_HALF_FAST;
         DSI_MODE_MID:  next_half = DSI_HALF_MID;
         DSI_MODE_SLOW: next_half = DSI_HALF_SLOW;
         default:       next_half = DSI_HALF_FAST;
      endcase
      if (clock_source_select) begin
         next_half = next_half << DSI_CKS_SHIFT;
      end
   end

   dsi_baud u_baud (
      .clk  (clk),
      .rst  (rst),
      .run  (master_busy),
      .half (next_half),
      .tick (tick)
   );

   // ****************************************************************
   // APB slave: one wait state so read data comes from a flop
   // ****************************************************************
   assign acc     = psel && penable && pready;
   assign wr_en   = acc && pwrite;
   assign map_hit = (paddr == DSI_ADDR_CTRL) || (paddr == DSI_ADDR_DATA) ||
                    (paddr == DSI_ADDR_CFG)  || (paddr == DSI_ADDR_STAT);
   assign data_wr = wr_en && (paddr == DSI_ADDR_DATA) && bus_enable_bit;

   // Answer and read mux; reading has no side effects
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !map_hit;
         case (paddr)
            DSI_ADDR_CTRL: prdata <= {24'h000000, clock_source_select, mode, bus_enable_bit,
                                      bit_order_select, select_enable_bit, write_collision_flag,
                                      transfer_done_flag};
            DSI_ADDR_DATA: prdata <= {24'h000000, serial_port_data};
            DSI_ADDR_CFG:  prdata <= {30'h00000000, write_collision_flag_en, cpol};
            DSI_ADDR_STAT: prdata <= {27'h0000000, busy, slave_bits};
            default:       prdata <= 32'h00000000;
         endcase
      end
   end

   // Configuration; control fields written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         clock_source_select <= DSI_CTRL_RESET[DSI_BIT_CKS];
         mode                <= dsi_mode_e'(DSI_CTRL_RESET[DSI_BIT_M1:DSI_BIT_M0]);
         bus_enable_bit      <= DSI_CTRL_RESET[DSI_BIT_BUS_ENABLE_BIT];
         bit_order_select    <= DSI_CTRL_RESET[DSI_BIT_MLS];
         select_enable_bit   <= DSI_CTRL_RESET[DSI_BIT_SELECT_ENABLE];
         cpol                <= DSI_CFG_RESET[DSI_BIT_CPOL];
         write_collision_flag_en             <= DSI_CFG_RESET[DSI_BIT_WRITE_COLLISION_FLAG_EN];
      end else if (wr_en) begin
         if (paddr == DSI_ADDR_CTRL) begin
            clock_source_select <= pwdata[DSI_BIT_CKS];
            mode                <= dsi_mode_e'(pwdata[DSI_BIT_M1:DSI_BIT_M0]);
            bus_enable_bit      <= pwdata[DSI_BIT_BUS_ENABLE_BIT];
            bit_order_select    <= pwdata[DSI_BIT_MLS];
            select_enable_bit   <= pwdata[DSI_BIT_SELECT_ENABLE];
         end else if (paddr == DSI_ADDR_CFG) begin
            cpol    <= pwdata[DSI_BIT_CPOL];
            write_collision_flag_en <= pwdata[DSI_BIT_WRITE_COLLISION_FLAG_EN];
         end
      end
   end

   // ****************************************************************
   // Transfer control
   // ****************************************************************
   assign is_master = (mode != DSI_MODE_SLAVE);
   assign busy      = master_busy || (slave_bits != 4'h0);
   assign collide   = data_wr && busy;

   // Slave selection: select line gates only when enabled
   assign slave_sel  = !select_enable_bit || !link.clean[DSI_LANE_CS];
   assign sclk_s     = link.clean[DSI_LANE_SCLK];
   assign lead_edge  = slave_sel && (sclk_prev == cpol) && (sclk_s != cpol);

   // Master: even half steps sample, odd ones shift. Slave samples and shifts at the seen
   // leading edge: waiting for the trailing edge would put the next bit out too late
   assign sample_now = is_master ? (master_busy && tick && !half_step[0])
                                 : (bus_enable_bit && lead_edge);
   assign shift_now  = is_master ? (master_busy && tick && half_step[0])
                                 : (bus_enable_bit && lead_edge);
   assign in_bit     = is_master ? sampled_bit : link.clean[DSI_LANE_SDI];
   assign word_done  = shift_now && (is_master ? (half_step == DSI_HALF_STEPS - 5'h01)
                                               : (slave_bits == DSI_WORD_BITS - 4'h1));
   assign out_bit    = bit_order_select ? shift_buffer[0] : shift_buffer[7];

   // Edge history of the clean serial clock
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= sclk_s;
      end
   end

   // Master sequencing: a data write alone starts clocking
   always_ff @(posedge clk) begin
      if (rst || !bus_enable_bit) begin
         master_busy <= 1'b0;
         half_step   <= 5'h00;
      end else if (is_master && data_wr && !busy) begin
         master_busy <= 1'b1;
         half_step   <= 5'h00;
      end else if (master_busy && tick) begin
         if (word_done) begin
            master_busy <= 1'b0;
            half_step   <= 5'h00;
         end else begin
            half_step <= half_step + 5'h01;
         end
      end
   end

   // Slave bit count; deselect aborts a partial word
   always_ff @(posedge clk) begin
      if (rst || !bus_enable_bit || is_master || !slave_sel) begin
         slave_bits <= 4'h0;
      end else if (word_done) begin
         slave_bits <= 4'h0;
      end else if (shift_now) begin
         slave_bits <= slave_bits + 4'h1;
      end
   end

   // Shift buffer: loaded by data writes, sample then shift for full duplex
   always_ff @(posedge clk) begin
      if (data_wr && !busy) begin
         shift_buffer <= pwdata[7:0];
      end else if (shift_now) begin
         if (bit_order_select) begin
            shift_buffer <= {in_bit, shift_buffer[7:1]};
         end else begin
            shift_buffer <= {shift_buffer[6:0], in_bit};
         end
      end
   end

   // Input bit captured on the leading edge
   always_ff @(posedge clk) begin
      if (rst) begin
         sampled_bit <= 1'b0;
      end else if (sample_now) begin
         sampled_bit <= link.clean[DSI_LANE_SDI];
      end
   end

   // Readable data latch; deliberately no reset value
   always_ff @(posedge clk) begin
      if (word_done) begin
         if (bit_order_select) begin
            serial_port_data <= {in_bit, shift_buffer[7:1]};
         end else begin
            serial_port_data <= {shift_buffer[6:0], in_bit};
         end
      end
   end

   // Status flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst || !bus_enable_bit) begin
         transfer_done_flag   <= 1'b0;
         write_collision_flag <= 1'b0;
      end else begin
         if (word_done) begin
            transfer_done_flag <= 1'b1;
         end else if (data_wr && !busy) begin
            transfer_done_flag <= 1'b0;
         end else if (wr_en && paddr == DSI_ADDR_CTRL && !pwdata[DSI_BIT_TRF]) begin
            transfer_done_flag <= 1'b0;
         end
         if (collide && write_collision_flag_en) begin
            write_collision_flag <= 1'b1;
         end else if (wr_en && paddr == DSI_ADDR_CTRL && !pwdata[DSI_BIT_WRITE_COLLISION_FLAG]) begin
            write_collision_flag <= 1'b0;
         end
      end
   end

   // Request follows the done flag; nothing here depends on a core clock gate
   always_ff @(posedge clk) begin
      if (rst || !bus_enable_bit) begin
         serial_irq <= 1'b0;
      end else begin
         serial_irq <= word_done || (transfer_done_flag &&
                       !(wr_en && paddr == DSI_ADDR_CTRL && !pwdata[DSI_BIT_TRF]));
      end
   end

   // ****************************************************************
   // Pin drivers, all registered
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst || !bus_enable_bit) begin
         serial_out_line  <= 1'b1;
         serial_out_oe    <= 1'b0;
         serial_clock_out <= 1'b0;
         serial_clock_oe  <= 1'b0;
         slave_select_out <= 1'b1;
         slave_select_oe  <= 1'b0;
      end else begin
         serial_out_oe   <= 1'b1;
         serial_clock_oe <= is_master;
         slave_select_oe <= is_master && select_enable_bit;
         slave_select_out <= !master_busy;
         // High again as the word ends; a selected slave shows its first bit early
         if ((busy || (!is_master && slave_sel)) && !word_done) begin
            serial_out_line <= out_bit;
         end else begin
            serial_out_line <= 1'b1;
         end
         if (master_busy && tick) begin
            serial_clock_out <= half_step[0] ? cpol : !cpol;
         end else if (!master_busy) begin
            serial_clock_out <= cpol;
         end
      end
   end

endmodule

// *** dsi_spi_port_assertions.sv ***
// Checker for APB timing and pin behaviour of the SPI port
`timescale 1ns/1ps
module dsi_spi_port_assertions
   import dsi_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        serial_out_line,
   input wire logic        serial_out_oe,
   input wire logic        serial_clock_out,
   input wire logic        serial_clock_oe,
   input wire logic        slave_select_out,
   input wire logic        slave_select_oe,
   input wire logic        serial_irq
);
   // ****
   // Shadow state
   // ****
   logic [7:0] ctrl;
   logic       cpol;
   logic [8:0] st_q1;
   logic [8:0] st_q2;
   logic [4:0] edges;
   logic       sclk_q;
   logic       sel_q;
   logic       settled;
   logic       master;

   // Follow committed writes; the flags are left to the design
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= DSI_CTRL_RESET;
         cpol <= DSI_CFG_RESET[DSI_BIT_CPOL];
      end else if (psel && penable && pready && pwrite) begin
         if (paddr == DSI_ADDR_CTRL) ctrl <= pwdata[7:0];
         if (paddr == DSI_ADDR_CFG) cpol <= pwdata[DSI_BIT_CPOL];
      end
   end

   // Pins are registered, so judge them only once the setup is two cycles old
   always_ff @(posedge clk) begin
      st_q1 <= {cpol, ctrl};
      st_q2 <= st_q1;
   end
   assign settled = ({cpol, ctrl} == st_q1) && (st_q1 == st_q2);
   assign master  = ctrl[DSI_BIT_M1:DSI_BIT_M0] != DSI_MODE_SLAVE;

   // Clock toggles since the select line last fell; held after the word
   always_ff @(posedge clk) begin
      sclk_q <= serial_clock_out;
      sel_q  <= slave_select_out;
      if (rst || (!slave_select_out && sel_q)) edges <= 5'h00;
      else if (serial_clock_out != sclk_q) edges <= edges + 5'h01;
   end

   // ****
   // Properties
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_wait;
      psel && penable && !pready;
   endsequence
   sequence s_end;
      psel && penable && pready;
   endsequence

   a_one_wait: assert property ($rose(penable) && psel |-> s_wait ##1 s_end)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_unmapped_err: assert property (pready |-> pslverr == (paddr > DSI_ADDR_STAT || paddr[1:0] != 2'h0)
      && (!pslverr || prdata == 32'h0)) else $error("wrong error response");
   a_float_off: assert property (settled && !ctrl[DSI_BIT_BUS_ENABLE_BIT] |-> !serial_out_oe && !serial_clock_oe && !slave_select_oe)
      else $error("pin driven while bus disabled");
   a_select_gate: assert property (settled |-> slave_select_oe == (ctrl[DSI_BIT_BUS_ENABLE_BIT] && ctrl[DSI_BIT_SELECT_ENABLE] && master))
      else $error("select drive wrong");
   a_clk_float: assert property (settled && ctrl[DSI_BIT_BUS_ENABLE_BIT] && !master |-> !serial_clock_oe)
      else $error("slave drives clock");
   a_clk_idle: assert property (settled && ctrl[DSI_BIT_BUS_ENABLE_BIT] && master && serial_irq && !$past(psel)
      |-> serial_clock_oe && serial_clock_out == cpol) else $error("master clock not idle at polarity");
   a_idle_high: assert property (settled && ctrl[DSI_BIT_BUS_ENABLE_BIT] && master && serial_irq && !$past(psel)
      |-> serial_out_oe && serial_out_line) else $error("data out not high when idle");
   a_eight_bits: assert property ($rose(serial_irq) && master && ctrl[DSI_BIT_SELECT_ENABLE] |-> ##2 edges == 5'h10)
      else $error("word not sixteen clock edges");
   a_done_low: assert property ($fell(slave_select_out) && master |-> ##1 (!serial_irq) [*8])
      else $error("done flag high while shifting");
endmodule

bind dsi_spi_port dsi_spi_port_assertions dsi_spi_port_assertions_inst (
   .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .serial_out_line, .serial_out_oe, .serial_clock_out, .serial_clock_oe,
   .slave_select_out, .slave_select_oe, .serial_irq
);

// *** dsi_far_model.sv ***
// Far-side SPI device: slave to the port's master, or master clocking the port
`timescale 1ns/1ps
module dsi_far_model (
   input  wire logic       serial_out_line,
   input  wire logic       serial_clock_out,
   input  wire logic       slave_select_out,
   input  wire logic [7:0] tx,
   input  wire logic       lsb,
   input  wire logic       cpol,
   output logic            serial_in_line,
   output logic            serial_clock_in,
   output logic            slave_select_in,
   output logic [7:0]      rx
);
   logic [7:0] sh;

   // Idle: not selected, clock low
   initial begin
      serial_in_line = 1'h0;
      serial_clock_in = 1'h0;
      slave_select_in = 1'h1;
      sh = 8'h00;
      rx = 8'h00;
   end

   // Word load and shifts in the agreed order
   task automatic load();
      sh = tx;
      serial_in_line = lsb ? sh[0] : sh[7];
   endtask
   task automatic shift();
      sh = lsb ? sh >> 1 : sh << 1;
      serial_in_line = lsb ? sh[0] : sh[7];
   endtask
   task automatic grab();
      rx = lsb ? {serial_out_line, rx[7:1]} : {rx[6:0], serial_out_line};
   endtask

   // Slave role, clocked by the port
   always @(negedge slave_select_out) load();
   always @(posedge (serial_clock_out ^ cpol)) if (!slave_select_out) grab();
   always @(negedge (serial_clock_out ^ cpol)) if (!slave_select_out) shift();
   // Released line shows the inverse so a stale bit cannot pass
   always @(posedge slave_select_out) serial_in_line = ~serial_in_line;

   // Master role: eight clocks of 160 ns, select low throughout
   task automatic run_master();
      #5;
      slave_select_in = 1'h0;
      load();
      #160;
      repeat (8) begin
         grab();
         serial_clock_in = ~cpol;
         #80;
         serial_clock_in = cpol;
         shift();
         #80;
      end
      slave_select_in = 1'h1;
      serial_in_line = ~serial_in_line;
   endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the SPI port: registers, master and slave transfers
`timescale 1ns/1ps
module tb_top import dsi_pkg::*; ;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, tx, rx;
   logic [31:0] pwdata, prdata, rd;
   logic        serial_in_line, serial_out_line, serial_out_oe, serial_clock_in, serial_clock_out;
   logic        serial_clock_oe, slave_select_in, slave_select_out, slave_select_oe, serial_irq;
   logic        lsb, cpol;
   int          mismatches, num_checks;

   dsi_spi_port dsi_spi_port_inst (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .serial_in_line, .serial_out_line, .serial_out_oe, .serial_clock_in, .serial_clock_out,
      .serial_clock_oe, .slave_select_in, .slave_select_out, .slave_select_oe, .serial_irq
   );
   dsi_far_model dsi_far_model_inst (
      .serial_out_line, .serial_clock_out, .slave_select_out, .tx, .lsb, .cpol,
      .serial_in_line, .serial_clock_in, .slave_select_in, .rx
   );

   // ****
   // Helpers
   // ****
   // 50 MHz clock
   always #10 clk = ~clk;

   task automatic test_done();
      if (mismatches == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
      chk(n < 50, 1'h1);
   endtask

   task automatic wait_irq(output int n);
      n = 0;
      while (serial_irq !== 1'h1 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      chk(n < 5000, 1'h1);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      chk({serial_out_oe, serial_clock_oe, slave_select_oe}, 3'h0);
      apb(1'h0, DSI_ADDR_CTRL, 32'h0);
      chk(rd, 32'h60);
      apb(1'h0, DSI_ADDR_CFG, 32'h0);
      chk(rd, 32'h2);
      apb(1'h0, 8'h10, 32'h0);
      chk(err, 1'h1);
      chk(rd, 32'h0);
   endtask

   // Master word: duration from mode and clock source, data both ways
   task automatic t_master(input logic [1:0] m, input logic k, input logic l, input logic p,
                           input logic [7:0] b, input logic [7:0] f);
      int n;
      int e;
      e = (m == 2'h0) ? DSI_HALF_FAST : (m == 2'h1) ? DSI_HALF_MID : DSI_HALF_SLOW;
      e = (16 * e) << (k ? DSI_CKS_SHIFT : 0);
      lsb <= l;
      cpol <= p;
      tx <= f;
      apb(1'h1, DSI_ADDR_CFG, {30'h0, 1'h1, p});
      apb(1'h1, DSI_ADDR_CTRL, {24'h0, k, m, 1'h1, l, 1'h1, 2'h0});
      apb(1'h1, DSI_ADDR_DATA, {24'h0, b});
      wait_irq(n);
      chk(n >= e - 1 && n <= e + 4, 1'h1);
      apb(1'h0, DSI_ADDR_CTRL, 32'h0);
      chk(rd, {24'h0, k, m, 1'h1, l, 1'h1, 2'h1});
      apb(1'h0, DSI_ADDR_DATA, 32'h0);
      chk(rd, {24'h0, f});
      chk(rx, b);
   endtask

   // Second write while shifting is dropped and flagged
   task automatic t_collision();
      int n;
      lsb <= 1'h0;
      tx <= 8'h3C;
      apb(1'h1, DSI_ADDR_CTRL, 32'h14);
      apb(1'h1, DSI_ADDR_DATA, 32'h81);
      apb(1'h1, DSI_ADDR_DATA, 32'h7E);
      apb(1'h0, DSI_ADDR_DATA, 32'h0);
      chk(rd, 32'h5A);
      wait_irq(n);
      apb(1'h0, DSI_ADDR_CTRL, 32'h0);
      chk(rd, 32'h17);
      chk(rx, 8'h81);
      apb(1'h1, DSI_ADDR_CTRL, 32'h14);
      apb(1'h0, DSI_ADDR_CTRL, 32'h0);
      chk(rd, 32'h14);
   endtask

   // Slave word clocked by the far side
   task automatic t_slave();
      int n;
      cpol <= 1'h0;
      tx <= 8'h96;
      apb(1'h1, DSI_ADDR_CFG, 32'h2);
      apb(1'h1, DSI_ADDR_CTRL, 32'h74);
      apb(1'h1, DSI_ADDR_DATA, 32'hC3);
      dsi_far_model_inst.run_master();
      wait_irq(n);
      @(posedge clk);
      chk(rx, 8'hC3);
      apb(1'h0, DSI_ADDR_DATA, 32'h0);
      chk(rd, 32'h96);
   endtask

   // Bus enable off clears flags and floats every pin
   task automatic t_disable();
      apb(1'h1, DSI_ADDR_CTRL, 32'h60);
      apb(1'h0, DSI_ADDR_CTRL, 32'h0);
      chk(rd, 32'h60);
      chk({serial_out_oe, serial_clock_oe, slave_select_oe}, 3'h0);
   endtask

   // ****
   // Main sequence and watchdog
   // ****
   initial begin
      clk = 1'h0;
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      tx = 8'h00;
      lsb = 1'h0;
      cpol = 1'h0;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_reset();
      t_master(2'h0, 1'h0, 1'h0, 1'h0, 8'hA5, 8'h3C);
      t_master(2'h1, 1'h0, 1'h1, 1'h1, 8'h96, 8'hE1);
      t_master(2'h2, 1'h0, 1'h1, 1'h0, 8'h0F, 8'hC8);
      t_master(2'h1, 1'h1, 1'h0, 1'h0, 8'hD2, 8'h5A);
      t_collision();
      t_slave();
      t_disable();
      test_done();
   end

   // Whole run needs well under 10k cycles
   initial begin
      #1000000;
      mismatches++;
      test_done();
   end
endmodule
